// file: pid_pkg.sv
// package: address map, register layout and timing constants of the decoder
package pid_pkg;

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    localparam logic [7:0] PID_ISA_BUS_OPTIONS_OFS = 8'h40;
    localparam logic [7:0] PID_ROM_WINDOW_ENABLES_OFS = 8'h43;
    localparam logic [7:0] PID_BMIDE_BASE_OFS = 8'h20;
    localparam logic [7:0] PID_DDMA_BASE_OFS = 8'h48;
    localparam logic [7:0] PID_REG_RESET = 8'h00;
    localparam int PID_OPT_FLASH_WE_BIT = 0;
    localparam int PID_OPT_ROM_WAIT_BIT = 1;
    localparam int PID_ROMEN_FFFE_BIT = 7;
    localparam int PID_ROMEN_FFF8_BIT = 6;

    // ---------------------------------------------------------------
    // i/o map
    // ---------------------------------------------------------------
    localparam logic [15:0] PID_IDE1_BASE = 16'h01F0;
    localparam logic [15:0] PID_IDE2_BASE = 16'h0170;
    localparam logic [15:0] PID_IDE1_CTL = 16'h03F6;
    localparam logic [15:0] PID_IDE2_CTL = 16'h0376;
    localparam logic [15:0] PID_DMA1_LO = 16'h0000;
    localparam logic [15:0] PID_DMA1_HI = 16'h000F;
    localparam logic [15:0] PID_PAGE_LO = 16'h0080;
    localparam logic [15:0] PID_PAGE_HI = 16'h008F;
    localparam logic [15:0] PID_DMA2_LO = 16'h00C0;
    localparam logic [15:0] PID_DMA2_HI = 16'h00DF;
    localparam logic [15:0] PID_KBD_DATA = 16'h0060;
    localparam logic [15:0] PID_KBD_STAT = 16'h0064;
    localparam int PID_IDE_BLK_BITS = 3;
    localparam int PID_BMIDE_BITS = 4;
    localparam int PID_DDMA_BITS = 4;

    // ---------------------------------------------------------------
    // memory map
    // ---------------------------------------------------------------
    localparam logic [31:0] PID_ISA_LIMIT = 32'h0100_0000;
    localparam logic [23:0] PID_TOPROM_LO = 24'hF8_0000;
    localparam logic [31:0] PID_ROM_FFFE_LO = 32'hFFFE_0000;
    localparam logic [31:0] PID_ROM_FFFE_HI = 32'hFFFE_FFFF;
    localparam logic [31:0] PID_ROM_FFF8_LO = 32'hFFF8_0000;
    localparam logic [31:0] PID_ROM_FFF8_HI = 32'hFFFD_FFFF;
    localparam logic [31:0] PID_ROM_C_BASE = 32'h000C_0000;
    localparam logic [31:0] PID_BIOS_LO = 32'h000F_0000;
    localparam logic [31:0] PID_BIOS_HI = 32'h000F_FFFF;
    localparam int PID_ROM_BLK_BITS = 15;
    localparam int PID_ROM_BLKS = 6;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int PID_CLK_NS = 50;
    localparam int PID_ISA_CMD_NS = 300;
    localparam int PID_ROM_EXTRA_NS = 200;
    localparam logic [3:0] PID_ISA_CMD_CYC =
        4'((PID_ISA_CMD_NS + PID_CLK_NS - 1) / PID_CLK_NS);
    localparam logic [3:0] PID_ROM_EXTRA_CYC =
        4'((PID_ROM_EXTRA_NS + PID_CLK_NS - 1) / PID_CLK_NS);
    localparam logic [2:0] PID_DEVSEL_SLOW = 3'h3;
    localparam logic [2:0] PID_DEVSEL_SUB = 3'h4;

    typedef enum logic [2:0] {
        PID_IDLE = 3'b000,
        PID_WAIT = 3'b001,
        PID_ISA = 3'b010,
        PID_DONE = 3'b011,
        PID_DROP = 3'b100
    } pid_state_t;

    typedef enum logic [2:0] {
        PID_DST_NONE = 3'b000,
        PID_DST_IDE = 3'b001,
        PID_DST_BMIDE = 3'b010,
        PID_DST_ISA = 3'b011,
        PID_DST_ROM = 3'b100
    } pid_dest_t;

endpackage : pid_pkg

// file: pid_dec_if.sv
// interface: address decode results passed to the top module
interface pid_dec_if;
    import pid_pkg::*;
    logic ide_hit;
    logic bmide_hit;
    logic onchip_hit;
    logic kbd_hit;
    logic rom_hit;
    logic below_16m;
    logic bios_hit;
    modport dec (output ide_hit, bmide_hit, onchip_hit, kbd_hit, rom_hit,
        below_16m, bios_hit);
    modport use_ (input ide_hit, bmide_hit, onchip_hit, kbd_hit, rom_hit,
        below_16m, bios_hit);
endinterface : pid_dec_if

// file: pid_addr_dec.sv
// address decoder: combinational classification of a pci address
module pid_addr_dec
    import pid_pkg::*;
(
    // request
    input wire logic [31:0] addr_i,
    input wire logic is_io_i,
    // configuration
    input wire logic [7:0] rom_en_i,
    input wire logic [15:0] bmide_base_i,
    input wire logic [15:0] ddma_base_i,
    // results
    pid_dec_if.dec dec
);

    // ---------------------------------------------------------------
    // i/o decode
    // ---------------------------------------------------------------
    wire logic [15:0] io = addr_i[15:0];
    wire logic ide1 = (io[15:PID_IDE_BLK_BITS] ==
        PID_IDE1_BASE[15:PID_IDE_BLK_BITS]) || (io == PID_IDE1_CTL);
    wire logic ide2 = (io[15:PID_IDE_BLK_BITS] ==
        PID_IDE2_BASE[15:PID_IDE_BLK_BITS]) || (io == PID_IDE2_CTL);
    // 16 bytes, low 8 channel one, high 8 channel two
    wire logic bmide = io[15:PID_BMIDE_BITS] ==
        bmide_base_i[15:PID_BMIDE_BITS];
    wire logic dma_fixed = (io >= PID_DMA1_LO && io <= PID_DMA1_HI) ||
        (io >= PID_PAGE_LO && io <= PID_PAGE_HI) ||
        (io >= PID_DMA2_LO && io <= PID_DMA2_HI);
    wire logic ddma = io[15:PID_DDMA_BITS] == ddma_base_i[15:PID_DDMA_BITS];

    assign dec.ide_hit = is_io_i && (ide1 || ide2);
    assign dec.bmide_hit = is_io_i && bmide;
    assign dec.onchip_hit = is_io_i && (dma_fixed || ddma);
    assign dec.kbd_hit = is_io_i &&
        (io == PID_KBD_DATA || io == PID_KBD_STAT);

    // ---------------------------------------------------------------
    // memory decode
    // ---------------------------------------------------------------
    wire logic top512 = addr_i[23:0] >= PID_TOPROM_LO;
    wire logic fffe = addr_i >= PID_ROM_FFFE_LO &&
        addr_i <= PID_ROM_FFFE_HI && rom_en_i[PID_ROMEN_FFFE_BIT];
    wire logic fff8 = addr_i >= PID_ROM_FFF8_LO &&
        addr_i <= PID_ROM_FFF8_HI && rom_en_i[PID_ROMEN_FFF8_BIT];
    wire logic [31:0] cofs = addr_i - PID_ROM_C_BASE;
    wire logic [16:0] blk = cofs[31:PID_ROM_BLK_BITS];
    // one 32k block per enable bit, ascending from c0000
    wire logic cblk = addr_i >= PID_ROM_C_BASE &&
        blk < 17'(PID_ROM_BLKS) && rom_en_i[blk[2:0]];

    assign dec.rom_hit = !is_io_i && (top512 || fffe || fff8 || cblk);
    assign dec.below_16m = addr_i < PID_ISA_LIMIT;
    assign dec.bios_hit = addr_i >= PID_BIOS_LO &&
        addr_i <= PID_BIOS_HI;

endmodule : pid_addr_dec

// file: pid_steer.sv
// data steering: places pci bytes onto sd lanes and assembles reads
module pid_steer
    import pid_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    // control
    input wire logic [1:0] lane_i,
    input wire logic wide_i,
    input wire logic latch_i,
    input wire logic clear_i,
    // data
    input wire logic [31:0] ad_i,
    input wire logic [15:0] sd_i,
    output logic [15:0] sd_o,
    output logic [31:0] rd_o
);

    // ---------------------------------------------------------------
    // write side: byte lane chosen by low address
    // ---------------------------------------------------------------
    wire logic [15:0] pair = lane_i[1] ? ad_i[31:16] : ad_i[15:0];
    assign sd_o = (wide_i || !lane_i[0]) ? pair : {pair[15:8], pair[15:8]};

    // ---------------------------------------------------------------
    // read side: latch each piece into its lane, 8 or 16 bits at a time
    // ---------------------------------------------------------------
    logic [31:0] acc_r;
    wire logic [4:0] sh = {lane_i, 3'b000};
    wire logic [31:0] mask = (wide_i ? 32'h0000_FFFF : 32'h0000_00FF) << sh;
    wire logic [31:0] val = {16'h0000, sd_i} << sh;
    wire logic [31:0] acc_nxt = clear_i ? 32'h0000_0000 :
        (acc_r & ~mask) | (val & mask);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_r <= 32'h0000_0000;
        end else if (latch_i || clear_i) begin
            acc_r <= acc_nxt;
        end
    end

    // includes the piece on sd now, so the last piece is not lost
    assign rd_o = acc_nxt;

endmodule : pid_steer

// file: pid_decoder.sv
// top: pci-to-isa address decode, claim and steering
// Behaviour
// - bus master ide window 16 bytes relocatable
// - claim ide ports of both channels
// - dma ranges fixed, distributed dma relocatable
// - unclaimed i/o to isa, kbd select 60/64
// - i/o writes ad to sd, reads sd to ad
// - drive sd on writes and on-chip reads only
// - isa masters reach on-chip registers normally
// - devsel seen in windows means stay off
// - dma/master memory unclaimed goes isa, iochrdy
// - below 16m unclaimed: assert devsel, isa cycle
// - 8-32 bit accesses to 8/16-bit isa memory
// - above 16m alias to 24-bit isa address
// - top 512k of each 16m is rom
// - rom cycles assert chip select, set xbus_direction
// - rom wait option adds isa wait states
// - assemble multi-byte rom reads; serve isa masters
// - rom enable bits 7 and 6 high windows
// - enable bits 0-5 add 32k blocks
// - rom access dropped when another devsel
// - rom writes only with flash write enable
// - f0000-fffff only isa or rom
module pid_decoder
    import pid_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // configuration port
    input wire logic cfg_we_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    // pci target request
    input wire logic req_i,
    input wire logic req_io_i,
    input wire logic req_write_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [3:0] req_be_i,
    input wire logic [31:0] ad_i,
    input wire logic devsel_other_i,
    input wire logic isa_master_i,
    // pci answers
    output logic devsel_o,
    output logic done_o,
    output logic [31:0] ad_o,
    output logic [2:0] dest_o,
    output logic iochrdy_o,
    // isa side
    output logic [23:0] sa_o,
    input wire logic [15:0] sd_i,
    output logic [15:0] sd_o,
    output logic sd_oe_o,
    output logic iow_o,
    output logic ior_o,
    output logic memw_o,
    output logic memr_o,
    input wire logic isa16_i,
    // x-bus
    output logic rom_chip_select_o,
    output logic rom_or_keyboard_select_o,
    output logic xbus_direction_o
);

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    logic [7:0] isa_bus_options_r;
    logic [7:0] rom_window_enables_r;
    logic [15:0] bmide_base_r;
    logic [15:0] ddma_base_r;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            isa_bus_options_r <= PID_REG_RESET;
            rom_window_enables_r <= PID_REG_RESET;
            bmide_base_r <= 16'h0000;
            ddma_base_r <= 16'h0000;
        end else if (cfg_we_i) begin
            if (cfg_addr_i == PID_ISA_BUS_OPTIONS_OFS)
                isa_bus_options_r <= cfg_wdata_i[7:0];
            if (cfg_addr_i == PID_ROM_WINDOW_ENABLES_OFS)
                rom_window_enables_r <= cfg_wdata_i[7:0];
            if (cfg_addr_i == PID_BMIDE_BASE_OFS)
                bmide_base_r <= cfg_wdata_i;
            if (cfg_addr_i == PID_DDMA_BASE_OFS)
                ddma_base_r <= cfg_wdata_i;
        end
    end

    wire logic [15:0] cfg_rd =
        (cfg_addr_i == PID_ISA_BUS_OPTIONS_OFS) ? {8'h00, isa_bus_options_r} :
        (cfg_addr_i == PID_ROM_WINDOW_ENABLES_OFS) ?
            {8'h00, rom_window_enables_r} :
        (cfg_addr_i == PID_BMIDE_BASE_OFS) ? bmide_base_r :
        (cfg_addr_i == PID_DDMA_BASE_OFS) ? ddma_base_r :
        {13'h0000, dest_o};

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_rdata_o <= 16'h0000;
        end else begin
            cfg_rdata_o <= cfg_rd;
        end
    end

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    pid_dec_if dif ();
    logic [31:0] addr_r;
    logic io_r;
    logic wr_r;
    logic mst_r;

    pid_addr_dec u_dec (
        .addr_i(addr_r),
        .is_io_i(io_r),
        .rom_en_i(rom_window_enables_r),
        .bmide_base_i(bmide_base_r),
        .ddma_base_i(ddma_base_r),
        .dec(dif.dec)
    );

    wire logic positive = dif.ide_hit || dif.bmide_hit;
    wire logic flash_ok = isa_bus_options_r[PID_OPT_FLASH_WE_BIT];
    wire logic rom_wait = isa_bus_options_r[PID_OPT_ROM_WAIT_BIT];
    // bios area never waits on devsel: only isa or rom live there
    wire logic skip_wait = !io_r && dif.bios_hit;
    wire logic [2:0] isa_dest = dif.rom_hit ? PID_DST_ROM : PID_DST_ISA;
    // rom writes are dropped unless flash programming is enabled
    wire logic rom_wr_block = dif.rom_hit && wr_r && !flash_ok;

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    pid_state_t state_r;
    pid_state_t state_nxt;
    logic [2:0] win_r;
    logic [3:0] cnt_r;
    logic [1:0] lane_r;
    logic [1:0] lane_last_r;

    wire logic [3:0] cmd_len = (dif.rom_hit && rom_wait) ?
        4'(PID_ISA_CMD_CYC + PID_ROM_EXTRA_CYC) : PID_ISA_CMD_CYC;
    wire logic wide = isa16_i && !dif.rom_hit && !io_r;
    wire logic cmd_end = state_r == PID_ISA && cnt_r == 4'h1;
    wire logic last_piece = cmd_end && (lane_r == lane_last_r ||
        (wide && (lane_r + 2'd1) == lane_last_r));
    wire logic [1:0] lane_step = wide ? 2'd2 : 2'd1;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PID_IDLE: begin
                if (req_i)
                    state_nxt = PID_WAIT;
            end
            PID_WAIT: begin
                if (positive)
                    state_nxt = PID_DONE;
                else if (devsel_other_i && !skip_wait)
                    state_nxt = PID_DROP;
                else if (win_r == PID_DEVSEL_SUB || skip_wait)
                    state_nxt = rom_wr_block ? PID_DONE : PID_ISA;
            end
            PID_ISA: begin
                if (last_piece)
                    state_nxt = PID_DONE;
            end
            PID_DONE: state_nxt = PID_IDLE;
            PID_DROP: state_nxt = PID_IDLE;
            default: state_nxt = PID_IDLE;
        endcase
    end

    // first and last byte lane from the byte enables
    wire logic [1:0] be_first = req_be_i[0] ? 2'd0 : req_be_i[1] ? 2'd1 :
        req_be_i[2] ? 2'd2 : 2'd3;
    wire logic [1:0] be_last = req_be_i[3] ? 2'd3 : req_be_i[2] ? 2'd2 :
        req_be_i[1] ? 2'd1 : 2'd0;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= PID_IDLE;
            addr_r <= 32'h0000_0000;
            io_r <= 1'b0;
            wr_r <= 1'b0;
            mst_r <= 1'b0;
            win_r <= 3'h0;
            cnt_r <= 4'h0;
            lane_r <= 2'd0;
            lane_last_r <= 2'd0;
        end else begin
            state_r <= state_nxt;
            if (state_r == PID_IDLE && req_i) begin
                addr_r <= req_addr_i;
                io_r <= req_io_i;
                wr_r <= req_write_i;
                mst_r <= isa_master_i;
                win_r <= 3'h0;
                lane_r <= be_first;
                lane_last_r <= be_last;
            end
            if (state_r == PID_WAIT) begin
                win_r <= win_r + 3'h1;
                cnt_r <= cmd_len;
            end
            if (state_r == PID_ISA) begin
                cnt_r <= cmd_end ? cmd_len : cnt_r - 4'h1;
                if (cmd_end)
                    lane_r <= lane_r + lane_step;
            end
        end
    end

    // ---------------------------------------------------------------
    // data steering
    // ---------------------------------------------------------------
    logic [15:0] sd_w;
    logic [31:0] rd_w;
    pid_steer u_steer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .lane_i(io_r ? addr_r[1:0] : lane_r),
        .wide_i(wide || io_r),
        .latch_i(cmd_end && !wr_r),
        .clear_i(state_r == PID_IDLE && req_i),
        .ad_i(ad_i),
        .sd_i(sd_i),
        .sd_o(sd_w),
        .rd_o(rd_w)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    wire logic in_isa = state_nxt == PID_ISA;
    // aliased above 16m: upper bits simply dropped
    wire logic [23:0] sa_nxt = {addr_r[23:2], io_r ? addr_r[1:0] :
        lane_r};
    // on-chip reads: this device sources sd itself
    wire logic sd_drive = in_isa && (wr_r || (io_r && dif.onchip_hit));
    wire logic claim = state_r == PID_WAIT && !mst_r &&
        ((positive) || (state_nxt == PID_ISA && (io_r ||
        dif.below_16m || dif.rom_hit)) || (state_nxt == PID_DONE));

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            devsel_o <= 1'b0;
            done_o <= 1'b0;
            ad_o <= 32'h0000_0000;
            dest_o <= PID_DST_NONE;
            iochrdy_o <= 1'b1;
            sa_o <= 24'h00_0000;
            sd_o <= 16'h0000;
            sd_oe_o <= 1'b0;
            iow_o <= 1'b0;
            ior_o <= 1'b0;
            memw_o <= 1'b0;
            memr_o <= 1'b0;
            rom_chip_select_o <= 1'b0;
            rom_or_keyboard_select_o <= 1'b0;
            xbus_direction_o <= 1'b0;
        end else begin
            if (claim)
                devsel_o <= 1'b1;
            else if (state_r == PID_IDLE)
                devsel_o <= 1'b0;
            done_o <= state_r != PID_IDLE && state_nxt == PID_DONE;
            if (state_r == PID_WAIT && state_nxt != PID_WAIT)
                dest_o <= positive ? (dif.ide_hit ? PID_DST_IDE :
                    PID_DST_BMIDE) : state_nxt == PID_DROP ?
                    PID_DST_NONE : isa_dest;
            // master/dma cycles held off until the isa side resolves
            iochrdy_o <= !(mst_r && (state_r == PID_WAIT ||
                state_r == PID_ISA)) || state_nxt == PID_DONE;
            if (cmd_end && !wr_r)
                ad_o <= io_r ? {sd_i, sd_i} : rd_w;
            sa_o <= sa_nxt;
            sd_o <= sd_w;
            sd_oe_o <= sd_drive;
            iow_o <= in_isa && io_r && wr_r;
            ior_o <= in_isa && io_r && !wr_r;
            memw_o <= in_isa && !io_r && wr_r;
            memr_o <= in_isa && !io_r && !wr_r;
            rom_chip_select_o <= in_isa && !io_r && dif.rom_hit;
            rom_or_keyboard_select_o <= in_isa &&
                ((!io_r && dif.rom_hit) || dif.kbd_hit);
            xbus_direction_o <= in_isa && !wr_r;
        end
    end

endmodule : pid_decoder

// file: pid_monitor.sv
// checker: assertions on decoder ports
module pid_monitor
    import pid_pkg::*;
(
    // clock, reset, config
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic cfg_we_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [15:0] cfg_wdata_i,
    // request and answers
    input wire logic req_i,
    input wire logic [31:0] req_addr_i,
    input wire logic devsel_o,
    input wire logic done_o,
    input wire logic [2:0] dest_o,
    // isa and x-bus
    input wire logic [23:0] sa_o,
    input wire logic sd_oe_o,
    input wire logic iow_o,
    input wire logic ior_o,
    input wire logic memw_o,
    input wire logic memr_o,
    input wire logic rom_chip_select_o,
    input wire logic rom_or_keyboard_select_o,
    input wire logic xbus_direction_o
);
    timeunit 1ns / 1ns;
    // ----------------------
    // flash enable shadow
    // ----------------------
    logic flash_we_r;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i)
            flash_we_r <= 1'b0;
        else if (cfg_we_i && cfg_addr_i == PID_ISA_BUS_OPTIONS_OFS)
            flash_we_r <= cfg_wdata_i[PID_OPT_FLASH_WE_BIT];
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    ide_claim_a: assert property (
        done_o && dest_o == PID_DST_IDE |-> devsel_o && $past(req_i, 2))
        else $error("ide claim late");
    kbd_select_a: assert property (
        (ior_o || iow_o) && rom_or_keyboard_select_o
        |-> sa_o[15:0] == PID_KBD_DATA || sa_o[15:0] == PID_KBD_STAT)
        else $error("kbd port");
    write_drive_a: assert property (iow_o |-> sd_oe_o)
        else $error("iow undriven");
    offchip_read_a: assert property (
        ior_o && sa_o[15:8] != 8'h00 |-> !sd_oe_o)
        else $error("sd driven");
    alias_addr_a: assert property (
        memr_o |-> sa_o[23:2] == req_addr_i[23:2])
        else $error("bad alias");
    top_rom_a: assert property (
        memr_o && (&req_addr_i[23:19]) |-> rom_chip_select_o)
        else $error("no rom select");
    rom_dir_a: assert property (
        rom_chip_select_o && (memr_o || memw_o)
        |-> xbus_direction_o == memr_o)
        else $error("bad xbus dir");
    flash_gate_a: assert property (
        memw_o && rom_chip_select_o |-> flash_we_r)
        else $error("flash locked");
endmodule : pid_monitor

bind pid_decoder pid_monitor mon (
    .clock_i, .resetn_i, .cfg_we_i, .cfg_addr_i, .cfg_wdata_i, .req_i,
    .req_addr_i, .devsel_o, .done_o, .dest_o, .sa_o, .sd_oe_o, .iow_o,
    .ior_o, .memw_o, .memr_o, .rom_chip_select_o,
    .rom_or_keyboard_select_o, .xbus_direction_o
);

// file: pid_isa_slot.sv
// partner: isa slot and rom model
module pid_isa_slot (
    // isa bus
    input wire logic clock_i,
    input wire logic [23:0] sa_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] sd_i,
    output logic [15:0] sd_o,
    output logic [7:0] wr_byte_o
);
    timeunit 1ns / 1ns;
    logic [15:0] last_r = 16'h0000;
    // idle bus: inverse of last read
    assign sd_o = rd_i ? {sa_i[7:0] + 8'h01, sa_i[7:0]} : ~last_r;
    always @(posedge clock_i) begin
        if (rd_i)
            last_r <= sd_o;
        if (wr_i)
            wr_byte_o <= sd_i[7:0];
    end
endmodule : pid_isa_slot

// file: testbench.sv
// testbench: directed decode tests
module testbench
    import pid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, resetn_i = 1'b0, cfg_we_i = 1'b0, req_i = 1'b0;
    logic req_io_i = 1'b0, req_write_i = 1'b0, devsel_other_i = 1'b0;
    logic isa_master_i = 1'b0, isa16_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00, wr_byte;
    logic [15:0] cfg_wdata_i = 16'h0000, sd_i, sd_o, cfg_rdata_o, slot_sd;
    logic [31:0] req_addr_i = 32'h0, ad_i = 32'h0, ad_o;
    logic [3:0] req_be_i = 4'h1;
    logic [2:0] dest_o;
    logic [23:0] sa_o;
    logic devsel_o, done_o, iochrdy_o, sd_oe_o, iow_o, ior_o, memw_o, memr_o;
    logic rom_chip_select_o, rom_or_keyboard_select_o, xbus_direction_o;
    int n_mismatch, comparisons, cyc, ticks;
    int n_memw, n_oe, n_wait, n_dev;
    logic [15:0] ide_a [6] = '{16'h01F0, 16'h01F7, 16'h0170, 16'h0177,
        16'h03F6, 16'h0376};

    pid_decoder DUT (
        .clock_i, .resetn_i, .cfg_we_i, .cfg_addr_i, .cfg_wdata_i,
        .cfg_rdata_o, .req_i, .req_io_i, .req_write_i, .req_addr_i,
        .req_be_i, .ad_i, .devsel_other_i, .isa_master_i, .devsel_o,
        .done_o, .ad_o, .dest_o, .iochrdy_o, .sa_o, .sd_i, .sd_o, .sd_oe_o,
        .iow_o, .ior_o, .memw_o, .memr_o, .isa16_i, .rom_chip_select_o,
        .rom_or_keyboard_select_o, .xbus_direction_o
    );
    pid_isa_slot slot (.clock_i, .sa_i(sa_o), .rd_i(ior_o | memr_o),
        .wr_i(iow_o | memw_o), .sd_i(sd_o), .sd_o(slot_sd),
        .wr_byte_o(wr_byte));
    // shared sd: decoder wins while driving
    assign sd_i = sd_oe_o ? sd_o : slot_sd;

    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        ticks++;
        n_memw += memw_o;
        n_oe += ior_o & sd_oe_o;
        n_wait += !iochrdy_o;
        n_dev += memr_o & devsel_o;
        if (ticks == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cfg(input logic [7:0] a, input logic [15:0] d,
            input logic we);
        @(posedge clock_i) #2;
        {cfg_addr_i, cfg_wdata_i, cfg_we_i} = {a, d, we};
        @(posedge clock_i) #2;
        cfg_we_i = 1'b0;
        @(posedge clock_i) #2;
        check(cfg_rdata_o, we ? d : PID_REG_RESET);
    endtask : cfg

    // cyc counts edges from the take; no done: 0
    task automatic xfer(input logic [1:0] iw, input logic [31:0] a, d,
            input logic [3:0] be, input logic [1:0] om);
        @(posedge clock_i) #2;
        {req_io_i, req_write_i, devsel_other_i, isa_master_i} = {iw, om};
        {req_addr_i, ad_i, req_be_i, req_i} = {a, d, be, 1'b1};
        @(posedge clock_i) #2;
        req_i = 1'b0;
        cyc = 1;
        while (done_o !== 1'b1 && cyc < 40) begin
            @(posedge clock_i) #2;
            cyc++;
        end
        if (done_o !== 1'b1)
            cyc = 0;
        devsel_other_i = 1'b0;
    endtask : xfer

    task automatic run(input logic [1:0] iw, input logic [31:0] a,
            input logic [3:0] be, input logic [1:0] om, input int ec,
            input logic [2:0] ed);
        xfer(iw, a, 32'h0000_005A, be, om);
        check(cyc, ec);
        check(dest_o, ed);
    endtask : run

    task automatic end_of_test;
        $display("checks %0d fails %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10) @(posedge clock_i) #0;
        #2;
        resetn_i = 1'b1;
        cfg(PID_ISA_BUS_OPTIONS_OFS, 16'h0, 1'b0);
        cfg(PID_ROM_WINDOW_ENABLES_OFS, 16'h0, 1'b0);
        cfg(8'h7F, 16'h0, 1'b0);
        $display("test registers done");
        foreach (ide_a[i])
            run(2'b10, {16'h0, ide_a[i]}, 4'h1 << ide_a[i][1:0], 2'b00, 2,
                PID_DST_IDE);
        cfg(PID_BMIDE_BASE_OFS, 16'hD000, 1'b1);
        run(2'b10, 32'h0000_D00C, 4'h8, 2'b00, 2, PID_DST_BMIDE);
        run(2'b10, 32'h0000_D010, 4'h1, 2'b00, 12, PID_DST_ISA);
        $display("test ide done");
        run(2'b11, 32'h0000_01F8, 4'h1, 2'b00, 12, PID_DST_ISA);
        check(wr_byte, 8'h5A);
        run(2'b10, 32'h0000_01F8, 4'h1, 2'b00, 12, PID_DST_ISA);
        check(ad_o, 32'hF9F8_F9F8);
        check(n_oe, 0);
        run(2'b10, 32'h0000_0060, 4'h1, 2'b00, 12, PID_DST_ISA);
        run(2'b10, 32'h0000_0080, 4'h1, 2'b01, 12, PID_DST_ISA);
        check(32'(n_oe != 0), 1);
        $display("test isa io done");
        run(2'b00, 32'h000A_0000, 4'hF, 2'b00, 30, PID_DST_ISA);
        check(ad_o, 32'h0302_0100);
        check(32'(n_dev != 0), 1);
        isa16_i = 1'b1;
        run(2'b00, 32'h020A_0010, 4'hF, 2'b00, 18, PID_DST_ISA);
        check(ad_o, 32'h1312_1110);
        isa16_i = 1'b0;
        run(2'b00, 32'h000A_0000, 4'h1, 2'b10, 0, PID_DST_NONE);
        n_wait = 0;
        xfer(2'b00, 32'h000F_0000, 32'h0, 4'h1, 2'b10);
        check(dest_o, PID_DST_ISA);
        check(n_wait, 0);
        xfer(2'b00, 32'h000A_0004, 32'h0, 4'h1, 2'b01);
        check(32'(n_wait != 0), 1);
        check(dest_o, PID_DST_ISA);
        $display("test memory done");
        run(2'b00, 32'h00FF_FFF0, 4'h1, 2'b00, 12, PID_DST_ROM);
        check(ad_o[7:0], 8'hF0);
        run(2'b00, 32'hFFFF_FFF0, 4'hF, 2'b00, 30, PID_DST_ROM);
        check(ad_o, 32'hF3F2_F1F0);
        cfg(PID_ISA_BUS_OPTIONS_OFS, 16'h0002, 1'b1);
        run(2'b00, 32'h00FF_FFF0, 4'h1, 2'b00, 16, PID_DST_ROM);
        cfg(PID_ISA_BUS_OPTIONS_OFS, 16'h0000, 1'b1);
        run(2'b00, 32'h00FF_FFF0, 4'h1, 2'b10, 0, PID_DST_NONE);
        for (int i = 0; i < 6; i++) begin
            cfg(PID_ROM_WINDOW_ENABLES_OFS, 16'(1 << i), 1'b1);
            run(2'b00, PID_ROM_C_BASE + 32'(i * 32768), 4'h1, 2'b00, 12,
                PID_DST_ROM);
            run(2'b00, PID_ROM_C_BASE + 32'(((i + 1) % 6) * 32768), 4'h1,
                2'b00, 12, PID_DST_ISA);
        end
        cfg(PID_ROM_WINDOW_ENABLES_OFS, 16'h00C0, 1'b1);
        run(2'b00, 32'hFFFE_0000, 4'h1, 2'b00, 12, PID_DST_ROM);
        $display("test rom done");
        xfer(2'b01, 32'h00FF_FFF0, 32'h0000_0011, 4'h1, 2'b00);
        check(n_memw, 0);
        cfg(PID_ISA_BUS_OPTIONS_OFS, 16'h0001, 1'b1);
        xfer(2'b01, 32'h00FF_FFF0, 32'h0000_0011, 4'h1, 2'b00);
        check(32'(n_memw != 0), 1);
        $display("test flash done");
        end_of_test();
    end
endmodule : testbench
